// File: pkg/ep0c_cfg.svh
// Purpose: Constants of the endpoint-zero control-transfer handshake block.
// Assumes: Wishbone byte addresses are four times the register index.
// Notes: Offsets, field positions and reset values are defined here; the bench and checker repeat the byte addresses.
`ifndef EP0C_CFG_SVH
`define EP0C_CFG_SVH
// Register indexes; byte address is index times four
`define EP0C_IDX_SEL 6'h30
`define EP0C_IDX_CTL 6'h32
`define EP0C_IDX_DAT 6'h34
// Control register fields
`define EP0C_B_RESP_HI 15
`define EP0C_B_RESP_LO 14
`define EP0C_B_VALID 13
`define EP0C_B_FLUSH 12
`define EP0C_B_BUSY 11
`define EP0C_B_STATUS_STAGE_COMPLETE 10
`define EP0C_B_LEN_HI 8
`define EP0C_CTL_RST 16'h0800
`define EP0C_B_DIR 0
// Response codes
`define EP0C_RESP_NAK 2'h0
`define EP0C_RESP_BUF 2'h1
`define EP0C_RESP_STALL 2'h2
`define EP0C_LEN_W 9
`define EP0C_DEPTH 64
`endif

// File: pkg/ep0c_pkg.sv
// Purpose: Types shared by the endpoint-zero handshake block.
// Assumes: Encodings of stage and handshake are set by the serial engine.
// Notes: Stage codes arrive on STAGE_CODE.
package ep0c_pkg;
	typedef enum logic [1:0] {
		STG_SETUP = 2'h0,
		STG_DATA = 2'h1,
		STG_STATUS = 2'h2
	} ep0c_stage_t;
	typedef enum logic [2:0] {
		HS_ACK = 3'h0,
		HS_NAK = 3'h1,
		HS_STALL = 3'h2,
		HS_DATA = 3'h3,
		HS_ZLP = 3'h4
	} ep0c_hs_t;
	typedef enum {ST_IDLE, ST_RX, ST_TX} ep0c_state_t;
endpackage

// File: rtl/ep0c_mem.sv
// Purpose: Byte buffer for endpoint zero.
// Assumes: One write and one read port on the same clock.
// Notes: Read data comes from a register, one cycle after the address.
`timescale 1ns/1ps
module ep0c_mem #(
	parameter int DEPTH = 64,
	parameter int AW = 6
) (
	input wire logic clk,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [7:0] rdata
);
	logic [7:0] mem [DEPTH];

	// Storage write
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// Registered read keeps the output glitch free
	always_ff @(posedge clk) begin
		rdata <= mem[raddr];
	end
endmodule // ep0c_mem

// File: rtl/ep0c_ctrl.sv
// Purpose: Endpoint-zero handshake control with its Wishbone register.
// Assumes: Serial engine strobes are one-cycle pulses on MCLK.
// Notes: Handshake choice is frozen at the token of each transaction.
`timescale 1ns/1ps
`include "ep0c_cfg.svh"
module ep0c_ctrl #(
	parameter int DEPTH = `EP0C_DEPTH
) (
	input wire logic MCLK,
	input wire logic SRST,
	input wire logic [7:0] ADR_I,
	input wire logic [31:0] DAT_I,
	output logic [31:0] DAT_O,
	input wire logic WE_I,
	input wire logic [3:0] SEL_I,
	input wire logic CYC_I,
	input wire logic STB_I,
	output logic ACK_O,
	input wire logic [1:0] STAGE_CODE,
	input wire logic SETUP_TOK,
	input wire logic OUT_TOK,
	input wire logic IN_TOK,
	input wire logic RX_BYTE_VLD,
	input wire logic [7:0] RX_BYTE,
	input wire logic RX_DONE,
	input wire logic TX_RD,
	input wire logic TX_DONE,
	input wire logic AUTO_REQ,
	input wire logic SEQ_ERR,
	output logic HS_VALID,
	output logic [2:0] HS_CODE,
	output logic [7:0] TX_BYTE,
	output logic [8:0] TX_LEN,
	output logic NOT_READY_EVENT,
	output logic BUFFER_READY_EVENT
);
	localparam int AW = $clog2(DEPTH);
	// Named copy of the reset word so that its fields can be selected
	localparam logic [15:0] ctl_rst = `EP0C_CTL_RST;

	logic ack_r;
	logic [1:0] resp_r;
	logic valid_r;
	logic status_stage_complete_r;
	logic busy_r;
	logic dir_r;
	logic [8:0] len_r;
	logic [8:0] wr_ptr_r;
	logic [8:0] rd_ptr_r;
	logic [8:0] tx_ptr_r;
	ep0c_pkg::ep0c_state_t state_r;
	ep0c_pkg::ep0c_hs_t hs_lat_r;
	logic accept_r;
	logic data_xact_r;
	logic hs_valid_r;
	logic [2:0] hs_code_r;
	logic nrdy_r;
	logic brdy_r;
	logic [8:0] tx_len_r;
	logic [31:0] dat_r;
	logic [7:0] mem_rdata;

	// Index match on word address bits
	function automatic logic hit(input logic [7:0] a,
			input logic [5:0] idx);
		hit = (a[7:2] == idx);
	endfunction

	logic req;
	logic wr;
	logic rd;
	logic wr_ctl;
	logic wr_sel;
	logic wr_dat;
	logic rd_dat;
	logic sw_flush;
	logic sw_set_valid;
	logic rx_wr;
	logic cpu_wr;
	logic last_rd;
	logic [1:0] cur_resp;
	logic stage_data;
	logic stage_status;

	// Request taken once per cycle pair; ack follows one cycle later
	assign req = CYC_I & STB_I & ~ack_r;
	assign wr = req & WE_I;
	assign rd = req & ~WE_I;
	assign wr_ctl = wr & SEL_I[1] & hit(ADR_I, `EP0C_IDX_CTL);
	assign wr_sel = wr & SEL_I[0] & hit(ADR_I, `EP0C_IDX_SEL);
	assign wr_dat = wr & SEL_I[0] & hit(ADR_I, `EP0C_IDX_DAT);
	assign rd_dat = rd & hit(ADR_I, `EP0C_IDX_DAT);

	// Flush write: write direction only acts with data present
	assign sw_flush = wr_ctl & DAT_I[`EP0C_B_FLUSH]
		& (dir_r | valid_r);
	// Forced completion only in read direction; a 0 does nothing
	assign sw_set_valid = wr_ctl & dir_r & DAT_I[`EP0C_B_VALID];

	// Buffer traffic from the serial engine and from the CPU
	assign rx_wr = (state_r == ep0c_pkg::ST_RX) & accept_r & RX_BYTE_VLD
		& (wr_ptr_r < 9'(DEPTH));
	assign cpu_wr = wr_dat & dir_r & ~valid_r & (wr_ptr_r < 9'(DEPTH));
	assign last_rd = rd_dat & ~dir_r & valid_r
		& (rd_ptr_r + 9'h001 >= len_r);

	assign cur_resp = resp_r;
	assign stage_data = (STAGE_CODE == ep0c_pkg::STG_DATA);
	assign stage_status = (STAGE_CODE == ep0c_pkg::STG_STATUS);

	// Wishbone acknowledge: one cycle after the request is seen
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= req;
		end
	end

	// Read data; unmapped addresses answer with zero
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			dat_r <= 32'h0000_0000;
		end else if (rd) begin
			if (hit(ADR_I, `EP0C_IDX_CTL)) begin
				dat_r <= {16'h0000, resp_r, valid_r, 1'b0, busy_r,
					status_stage_complete_r, 1'b0, len_r};
			end else if (hit(ADR_I, `EP0C_IDX_SEL)) begin
				dat_r <= {31'h0000_0000, dir_r};
			end else if (hit(ADR_I, `EP0C_IDX_DAT)) begin
				dat_r <= {24'h00_0000, mem_rdata};
			end else begin
				dat_r <= 32'h0000_0000;
			end
		end
	end

	// Direction select steers the valid and flush behaviour
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			dir_r <= 1'b0;
		end else if (wr_sel) begin
			dir_r <= DAT_I[`EP0C_B_DIR];
		end
	end

	// Response code: software first, automatic loads override it
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			resp_r <= ctl_rst[`EP0C_B_RESP_HI:`EP0C_B_RESP_LO];
		end else begin
			if (wr_ctl & ~valid_r) begin
				resp_r <= DAT_I[`EP0C_B_RESP_HI:`EP0C_B_RESP_LO];
			end
			if (SEQ_ERR) begin
				resp_r <= `EP0C_RESP_STALL;
			end
			if (AUTO_REQ) begin
				resp_r <= `EP0C_RESP_BUF;
			end
			if (SETUP_TOK) begin
				resp_r <= `EP0C_RESP_NAK;
			end
		end
	end

	// Status-stage completion bit
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			status_stage_complete_r <= ctl_rst[`EP0C_B_STATUS_STAGE_COMPLETE];
		end else begin
			if (wr_ctl) begin
				status_stage_complete_r <= DAT_I[`EP0C_B_STATUS_STAGE_COMPLETE];
			end
			if (AUTO_REQ) begin
				status_stage_complete_r <= 1'b1;
			end
			if (SETUP_TOK) begin
				status_stage_complete_r <= 1'b0;
			end
		end
	end

	// Valid flag: hardware set is last so it wins over any clear
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			valid_r <= ctl_rst[`EP0C_B_VALID];
		end else begin
			if (sw_flush | last_rd) begin
				valid_r <= 1'b0;
			end
			if (state_r == ep0c_pkg::ST_TX && TX_DONE && dir_r) begin
				valid_r <= 1'b0;
			end
			if (sw_set_valid) begin
				valid_r <= 1'b1;
			end
			if (state_r == ep0c_pkg::ST_RX && RX_DONE && accept_r
					&& data_xact_r) begin
				valid_r <= 1'b1;
			end
		end
	end

	// Received length; cleared by flush or by reading everything
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			len_r <= ctl_rst[`EP0C_B_LEN_HI:0];
		end else begin
			if (sw_flush | last_rd) begin
				len_r <= 9'h000;
			end
			if (state_r == ep0c_pkg::ST_RX && RX_DONE && accept_r
					&& data_xact_r) begin
				len_r <= wr_ptr_r;
			end
		end
	end

	// Buffer fill pointer, shared by reception and CPU writes
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			wr_ptr_r <= 9'h000;
		end else begin
			if (sw_flush | last_rd) begin
				wr_ptr_r <= 9'h000;
			end else if (state_r == ep0c_pkg::ST_TX && TX_DONE
					&& dir_r) begin
				wr_ptr_r <= 9'h000;
			end else if (OUT_TOK && state_r == ep0c_pkg::ST_IDLE
					&& !dir_r && !valid_r) begin
				wr_ptr_r <= 9'h000;
			end else if (rx_wr | cpu_wr) begin
				wr_ptr_r <= wr_ptr_r + 9'h001;
			end
		end
	end

	// CPU read pointer walks the received bytes
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			rd_ptr_r <= 9'h000;
		end else if (sw_flush | last_rd) begin
			rd_ptr_r <= 9'h000;
		end else if (rd_dat & ~dir_r & valid_r) begin
			rd_ptr_r <= rd_ptr_r + 9'h001;
		end
	end

	// Transmit pointer restarts at each IN token
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			tx_ptr_r <= 9'h000;
		end else if (IN_TOK && state_r == ep0c_pkg::ST_IDLE) begin
			tx_ptr_r <= 9'h000;
		end else if (state_r == ep0c_pkg::ST_TX && TX_RD) begin
			tx_ptr_r <= tx_ptr_r + 9'h001;
		end
	end

	// Transaction sequencing; the answer is frozen at the token so
	// a response change mid packet only affects the next one
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			state_r <= ep0c_pkg::ST_IDLE;
			hs_lat_r <= ep0c_pkg::HS_NAK;
			accept_r <= 1'b0;
			data_xact_r <= 1'b0;
		end else begin
			case (state_r)
			ep0c_pkg::ST_IDLE: begin
				if (SETUP_TOK) begin
					state_r <= ep0c_pkg::ST_RX;
					hs_lat_r <= ep0c_pkg::HS_ACK;
					accept_r <= 1'b0;
					data_xact_r <= 1'b0;
				end else if (OUT_TOK) begin
					state_r <= ep0c_pkg::ST_RX;
					data_xact_r <= stage_data;
					accept_r <= 1'b0;
					if (cur_resp[1]) begin
						hs_lat_r <= ep0c_pkg::HS_STALL;
					end else if (cur_resp == `EP0C_RESP_NAK) begin
						hs_lat_r <= ep0c_pkg::HS_NAK;
					end else if (stage_data) begin
						if (!dir_r && !valid_r) begin
							hs_lat_r <= ep0c_pkg::HS_ACK;
							accept_r <= 1'b1;
						end else begin
							hs_lat_r <= ep0c_pkg::HS_NAK;
						end
					end else if (stage_status && status_stage_complete_r && dir_r) begin
						hs_lat_r <= ep0c_pkg::HS_ACK;
					end else begin
						hs_lat_r <= ep0c_pkg::HS_NAK;
					end
				end else if (IN_TOK) begin
					accept_r <= 1'b0;
					data_xact_r <= stage_data;
					if (!cur_resp[1] && cur_resp != `EP0C_RESP_NAK
							&& stage_data && dir_r && valid_r) begin
						state_r <= ep0c_pkg::ST_TX;
					end else if (!cur_resp[1]
							&& cur_resp != `EP0C_RESP_NAK
							&& stage_status && status_stage_complete_r && !dir_r) begin
						state_r <= ep0c_pkg::ST_TX;
					end
				end
			end
			ep0c_pkg::ST_RX: begin
				if (RX_DONE) begin
					state_r <= ep0c_pkg::ST_IDLE;
				end
			end
			ep0c_pkg::ST_TX: begin
				if (TX_DONE) begin
					state_r <= ep0c_pkg::ST_IDLE;
				end
			end
			default: begin
				state_r <= ep0c_pkg::ST_IDLE;
			end
			endcase
		end
	end

	// Handshake pulse: IN answers at the token, OUT and setup at the
	// end of their data packet
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			hs_valid_r <= 1'b0;
			hs_code_r <= ep0c_pkg::HS_NAK;
		end else begin
			hs_valid_r <= 1'b0;
			if (state_r == ep0c_pkg::ST_RX && RX_DONE) begin
				hs_valid_r <= 1'b1;
				hs_code_r <= hs_lat_r;
			end else if (state_r == ep0c_pkg::ST_IDLE && IN_TOK
					&& !SETUP_TOK) begin
				hs_valid_r <= 1'b1;
				if (cur_resp[1]) begin
					hs_code_r <= ep0c_pkg::HS_STALL;
				end else if (cur_resp == `EP0C_RESP_NAK) begin
					hs_code_r <= ep0c_pkg::HS_NAK;
				end else if (stage_data) begin
					hs_code_r <= (dir_r && valid_r) ?
						ep0c_pkg::HS_DATA :
						ep0c_pkg::HS_NAK;
				end else if (stage_status && status_stage_complete_r && !dir_r) begin
					hs_code_r <= ep0c_pkg::HS_ZLP;
				end else begin
					hs_code_r <= ep0c_pkg::HS_NAK;
				end
			end
		end
	end

	// Not-ready and buffer-ready event pulses
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			nrdy_r <= 1'b0;
			brdy_r <= 1'b0;
		end else begin
			nrdy_r <= state_r == ep0c_pkg::ST_IDLE && !SETUP_TOK
				&& resp_r == `EP0C_RESP_BUF && stage_data
				&& ((OUT_TOK && (dir_r || valid_r))
				|| (IN_TOK && !(dir_r && valid_r)));
			brdy_r <= state_r == ep0c_pkg::ST_RX && RX_DONE
				&& accept_r && data_xact_r;
		end
	end

	// Busy while a transaction owns the buffer; set by reset
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			busy_r <= ctl_rst[`EP0C_B_BUSY];
		end else begin
			busy_r <= (state_r != ep0c_pkg::ST_IDLE);
		end
	end

	// Length offered to the transmitter, taken at the IN token
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			tx_len_r <= 9'h000;
		end else if (IN_TOK && state_r == ep0c_pkg::ST_IDLE) begin
			tx_len_r <= (stage_data && dir_r) ? wr_ptr_r : 9'h000;
		end
	end

	// Buffer memory; reads follow the transmitter while it sends
	ep0c_mem #(
		.DEPTH(DEPTH),
		.AW(AW)
	) u_mem (
		.clk(MCLK),
		.we(rx_wr | cpu_wr),
		.waddr(wr_ptr_r[AW-1:0]),
		.wdata(rx_wr ? RX_BYTE : DAT_I[7:0]),
		.raddr((state_r == ep0c_pkg::ST_TX) ? tx_ptr_r[AW-1:0] :
			rd_ptr_r[AW-1:0]),
		.rdata(mem_rdata)
	);

	// Outputs straight from flip-flops
	assign ACK_O = ack_r;
	assign DAT_O = dat_r;
	assign HS_VALID = hs_valid_r;
	assign HS_CODE = hs_code_r;
	assign TX_BYTE = mem_rdata;
	assign TX_LEN = tx_len_r;
	assign NOT_READY_EVENT = nrdy_r;
	assign BUFFER_READY_EVENT = brdy_r;
endmodule // ep0c_ctrl

// File: dv/ep0c_ctrl_checker.sv
// Purpose: Port checks for the endpoint-zero handshake block.
// Assumes: Tokens only come while the block is idle.
// Notes: Bound into every ep0c_ctrl; one clock domain.
`timescale 1ns/1ps
module ep0c_ctrl_checker (
	input wire logic MCLK,
	input wire logic SRST,
	input wire logic [7:0] ADR_I,
	input wire logic [31:0] DAT_O,
	input wire logic WE_I,
	input wire logic ACK_O,
	input wire logic SETUP_TOK,
	input wire logic OUT_TOK,
	input wire logic IN_TOK,
	input wire logic RX_DONE,
	input wire logic HS_VALID,
	input wire logic [2:0] HS_CODE,
	input wire logic NOT_READY_EVENT,
	input wire logic BUFFER_READY_EVENT
);
	logic in_setup_r;
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (SRST);
	// Marks a setup packet, whose answer ignores the response code
	always_ff @(posedge MCLK) begin
		in_setup_r <= !SRST && (SETUP_TOK || (in_setup_r && !RX_DONE));
	end
	// Handshake timing and codes against their causes
	setup_ack_a: assert property (
		RX_DONE && in_setup_r |=> HS_VALID && HS_CODE == ep0c_pkg::HS_ACK)
		else $error("setup packet not acked");
	rx_answer_a: assert property (RX_DONE |=> HS_VALID)
		else $error("no handshake after packet");
	in_answer_a: assert property (IN_TOK |=> HS_VALID)
		else $error("no answer to in token");
	in_nak_a: assert property (
		IN_TOK ##1 NOT_READY_EVENT |-> HS_CODE == ep0c_pkg::HS_NAK)
		else $error("not ready without nak");
	nrdy_cause_a: assert property (
		NOT_READY_EVENT |-> $past(IN_TOK || OUT_TOK))
		else $error("not ready event without token");
	rdy_event_a: assert property (
		BUFFER_READY_EVENT |-> $past(RX_DONE) && HS_CODE == ep0c_pkg::HS_ACK)
		else $error("ready event without accepted packet");
	resv_zero_a: assert property (
		ACK_O && !WE_I && ADR_I == 8'hc8 |-> !DAT_O[9])
		else $error("reserved bit reads one");
	hs_cause_a: assert property (
		HS_VALID |-> $past(IN_TOK) || $past(RX_DONE))
		else $error("handshake without token or packet end");
	cover property (HS_VALID && HS_CODE == ep0c_pkg::HS_ZLP);
	cover property (HS_VALID && HS_CODE == ep0c_pkg::HS_STALL);
	cover property (NOT_READY_EVENT);
endmodule // ep0c_ctrl_checker
bind ep0c_ctrl ep0c_ctrl_checker u_chk (.MCLK, .SRST, .ADR_I, .DAT_O,
	.WE_I, .ACK_O, .SETUP_TOK, .OUT_TOK, .IN_TOK, .RX_DONE, .HS_VALID,
	.HS_CODE, .NOT_READY_EVENT, .BUFFER_READY_EVENT);

// File: dv/ep0c_sie_model.sv
// Purpose: Host and serial engine side of endpoint zero.
// Assumes: Called right after a rising edge of clk.
// Notes: gap inserts idle cycles between bytes to model a slow host.
`timescale 1ns/1ps
module ep0c_sie_model (
	input wire logic clk,
	output logic [1:0] stage,
	output logic setup_tok,
	output logic out_tok,
	output logic in_tok,
	output logic rx_vld,
	output logic [7:0] rx_byte,
	output logic rx_done,
	output logic tx_rd,
	output logic tx_done,
	input wire logic hs_valid,
	input wire logic [2:0] hs_code,
	input wire logic [7:0] tx_byte,
	input wire logic [8:0] tx_len
);
	logic [7:0] got[$];
	logic [8:0] txl;
	initial begin
		stage = 2'h0;
		{setup_tok, out_tok, in_tok, rx_vld, rx_done, tx_rd, tx_done} = 7'h00;
		rx_byte = 8'h00;
	end
	// One transaction: token, payload, handshake, then send if asked
	task automatic xfer(input logic [1:0] s, input logic [1:0] kind,
		input int n, input int gap, output logic [2:0] hs);
		got.delete();
		stage <= s;
		setup_tok <= (kind == 2'h0);
		out_tok <= (kind == 2'h1);
		in_tok <= (kind == 2'h2);
		@(posedge clk);
		{setup_tok, out_tok, in_tok} <= 3'h0;
		if (kind != 2'h2) begin
			for (int i = 0; i < n; i++) begin
				// Idle gap: stale byte never looks valid
				if (gap > 0) begin
					rx_vld <= 1'b0;
					rx_byte <= ~rx_byte;
					repeat (gap) @(posedge clk);
				end
				rx_vld <= 1'b1;
				rx_byte <= 8'ha0 + 8'(i);
				@(posedge clk);
			end
			rx_vld <= 1'b0;
			rx_done <= 1'b1;
			@(posedge clk);
			rx_done <= 1'b0;
		end
		// A missing answer is left to the bench watchdog
		do begin
			@(posedge clk);
		end while (hs_valid !== 1'b1);
		hs = hs_code;
		txl = tx_len;
		for (int i = 0; hs == ep0c_pkg::HS_DATA && i < 9'(txl); i++) begin
			repeat (2) @(posedge clk);
			got.push_back(tx_byte);
			tx_rd <= 1'b1;
			@(posedge clk);
			tx_rd <= 1'b0;
		end
		if (hs == ep0c_pkg::HS_DATA || hs == ep0c_pkg::HS_ZLP) begin
			tx_done <= 1'b1;
			@(posedge clk);
			tx_done <= 1'b0;
		end
		repeat (3) @(posedge clk);
	endtask
endmodule // ep0c_sie_model

// File: dv/test_ep0_control_transfer_ctrl.sv
// Purpose: Register and handshake tests of the endpoint-zero block.
// Assumes: Register at byte address 0xc8, select 0xc0, data port 0xd0.
// Notes: Event pulses are counted and compared as deltas.
`timescale 1ns/1ps
module test_ep0_control_transfer_ctrl;
	localparam logic [7:0] SELR = 8'hc0;
	localparam logic [7:0] CTL = 8'hc8;
	localparam logic [7:0] DAT = 8'hd0;
	localparam logic [1:0] KS = 2'h0;
	localparam logic [1:0] KO = 2'h1;
	localparam logic [1:0] KI = 2'h2;
	logic mclk, srst, we, cyc, stb, ack, areq, serr;
	logic [7:0] adr;
	logic [31:0] dat_i, dat_o;
	logic [3:0] sel;
	logic [1:0] stg;
	logic stok, otok, itok, rxv, rxd, txr, txd, hsv, nre, bre;
	logic [7:0] rxb, txb;
	logic [2:0] hsc, h, e;
	logic [8:0] tlen;
	logic [15:0] q;
	int n_mismatch = 0;
	int num_checks = 0;
	int nr = 0;
	int br = 0;
	int n0;
	ep0c_ctrl uut (.MCLK(mclk), .SRST(srst), .ADR_I(adr), .DAT_I(dat_i),
		.DAT_O(dat_o), .WE_I(we), .SEL_I(sel), .CYC_I(cyc), .STB_I(stb),
		.ACK_O(ack), .STAGE_CODE(stg), .SETUP_TOK(stok), .OUT_TOK(otok),
		.IN_TOK(itok), .RX_BYTE_VLD(rxv), .RX_BYTE(rxb), .RX_DONE(rxd),
		.TX_RD(txr), .TX_DONE(txd), .AUTO_REQ(areq), .SEQ_ERR(serr),
		.HS_VALID(hsv), .HS_CODE(hsc), .TX_BYTE(txb), .TX_LEN(tlen),
		.NOT_READY_EVENT(nre), .BUFFER_READY_EVENT(bre));
	ep0c_sie_model sie (.clk(mclk), .stage(stg), .setup_tok(stok),
		.out_tok(otok), .in_tok(itok), .rx_vld(rxv), .rx_byte(rxb),
		.rx_done(rxd), .tx_rd(txr), .tx_done(txd), .hs_valid(hsv),
		.hs_code(hsc), .tx_byte(txb), .tx_len(tlen));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// Event pulses last one cycle, so each edge is counted
	always @(posedge mclk) begin
		nr <= nr + int'(nre === 1'b1);
		br <= br + int'(bre === 1'b1);
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Classic cycle: hold everything until ack, then release
	task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
		{cyc, stb, we, adr, dat_i} <= {1'b1, 1'b1, w, a, 16'h0000, d};
		do begin
			@(posedge mclk);
		end while (ack !== 1'b1);
		q = dat_o[15:0];
		{cyc, stb, we} <= 3'h0;
		@(posedge mclk);
	endtask
	task automatic rc(input logic [7:0] a, input logic [15:0] x);
		wb(1'b0, a, 16'h0000);
		chk(q, x);
	endtask
	task automatic tr(input logic [1:0] s, input logic [1:0] k, input int n,
		input int g, input logic [2:0] x);
		sie.xfer(s, k, n, g, h);
		chk({13'h0000, h}, {13'h0000, x});
	endtask
	task automatic fin(input string s);
		$display("test %s done", s);
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// A hang ends the run through the normal closing path
	initial begin
		#300000;
		n_mismatch++;
		stop_test;
	end
	initial begin
		{srst, cyc, stb, we, areq, serr} = 6'h20;
		{adr, dat_i, sel} = {8'h00, 32'h0000_0000, 4'hf};
		repeat (16) @(posedge mclk);
		srst <= 1'b0;
		rc(CTL, 16'h0800);
		rc(CTL, 16'h0000);
		wb(1'b1, CTL, 16'h3bff);
		rc(CTL, 16'h0000);
		fin("fields");
		for (int c = 0; c < 4; c++) begin
			if (c != 1) begin
				e = (c == 0) ? ep0c_pkg::HS_NAK : ep0c_pkg::HS_STALL;
				wb(1'b1, CTL, {c[1:0], 14'h0000});
				tr(ep0c_pkg::STG_DATA, KO, 2, 0, e);
				tr(ep0c_pkg::STG_STATUS, KI, 0, 0, e);
			end
		end
		n0 = br;
		wb(1'b1, CTL, 16'h4000);
		tr(ep0c_pkg::STG_DATA, KO, 2, 0, ep0c_pkg::HS_ACK);
		chk(16'(br - n0), 16'h0001);
		rc(CTL, 16'h6002);
		wb(1'b1, CTL, 16'hc000);
		rc(CTL, 16'h6002);
		n0 = nr;
		tr(ep0c_pkg::STG_DATA, KO, 1, 0, ep0c_pkg::HS_NAK);
		chk(16'(nr - n0), 16'h0001);
		for (int i = 0; i < 2; i++) begin
			wb(1'b0, DAT, 16'h0000);
			chk({8'h00, q[7:0]}, 16'h00a0 + 16'(i));
		end
		rc(CTL, 16'h4000);
		fin("write data");
		fork
			tr(ep0c_pkg::STG_DATA, KO, 2, 4, ep0c_pkg::HS_ACK);
			begin
				repeat (5) @(posedge mclk);
				wb(1'b1, CTL, 16'h0000);
			end
		join
		rc(CTL, 16'h2002);
		wb(1'b1, CTL, 16'h1000);
		rc(CTL, 16'h0000);
		wb(1'b1, CTL, 16'h4000);
		tr(ep0c_pkg::STG_STATUS, KI, 0, 0, ep0c_pkg::HS_NAK);
		wb(1'b1, CTL, 16'h4400);
		tr(ep0c_pkg::STG_STATUS, KI, 0, 0, ep0c_pkg::HS_ZLP);
		fin("status");
		for (int c = 0; c < 4; c++) begin
			wb(1'b1, CTL, {c[1:0], 14'h0400});
			tr(ep0c_pkg::STG_SETUP, KS, 8, 0, ep0c_pkg::HS_ACK);
			rc(CTL, 16'h0000);
		end
		areq <= 1'b1;
		@(posedge mclk);
		areq <= 1'b0;
		repeat (2) @(posedge mclk);
		rc(CTL, 16'h4400);
		tr(ep0c_pkg::STG_STATUS, KI, 0, 0, ep0c_pkg::HS_ZLP);
		serr <= 1'b1;
		@(posedge mclk);
		serr <= 1'b0;
		repeat (2) @(posedge mclk);
		wb(1'b0, CTL, 16'h0000);
		chk(q & 16'hc000, 16'h8000);
		tr(ep0c_pkg::STG_STATUS, KI, 0, 0, ep0c_pkg::HS_STALL);
		fin("auto codes");
		tr(ep0c_pkg::STG_SETUP, KS, 8, 0, ep0c_pkg::HS_ACK);
		wb(1'b1, SELR, 16'h0001);
		wb(1'b1, CTL, 16'h4000);
		n0 = nr;
		tr(ep0c_pkg::STG_DATA, KI, 0, 0, ep0c_pkg::HS_NAK);
		chk(16'(nr - n0), 16'h0001);
		for (int i = 0; i < 3; i++) begin
			wb(1'b1, DAT, 16'h0051 + 16'(i));
		end
		wb(1'b1, CTL, 16'h6000);
		tr(ep0c_pkg::STG_DATA, KI, 0, 0, ep0c_pkg::HS_DATA);
		chk({7'h00, sie.txl}, 16'h0003);
		for (int i = 0; i < 3; i++) begin
			chk({8'h00, sie.got[i]}, 16'h0051 + 16'(i));
		end
		rc(CTL, 16'h4000);
		wb(1'b1, DAT, 16'h0077);
		wb(1'b1, CTL, 16'h2000);
		wb(1'b1, CTL, 16'h1000);
		rc(CTL, 16'h0000);
		tr(ep0c_pkg::STG_DATA, KI, 0, 0, ep0c_pkg::HS_NAK);
		chk({7'h00, tlen}, 16'h0000);
		wb(1'b1, CTL, 16'h4400);
		tr(ep0c_pkg::STG_STATUS, KO, 0, 0, ep0c_pkg::HS_ACK);
		wb(1'b1, CTL, 16'h4000);
		tr(ep0c_pkg::STG_STATUS, KO, 0, 0, ep0c_pkg::HS_NAK);
		fin("read direction");
		stop_test;
	end
endmodule // test_ep0_control_transfer_ctrl
